// >>> hw/smp_ctrl.sv
// mode, power, output and fast-settle control behind two config words
// assumes the serial shifter presents whole words with a one-cycle strobe
//
// Operation
// - mute both outputs when enabled and unlocked
// - buffer pin gates outputs unless ignore set
// - method 0: last used core, else lowest
// - method 1: start at pick, skip invalid
// - method 2: force pick core; 3 reserved
// - source select: VCO, divided, external; 3 reserved
// - zero-delay bit feeds back from channel divider
// - mode 0 PLL+VCO, mode 1 PLL only
// - power state decode qualified by chip-enable
// - reset bit write restores defaults, self-releases
// - write with reset clear only updates fields
// - delay code selects minimum pump on-time
// - fast-settle engaged by counter or force bit
// - counter runs two times N reference cycles
// - fast-settle pump gain used while engaged
`timescale 1ns/1ps
`include "smp_regs.svh"
module smp_ctrl (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   reg_wr,
	input  wire logic [`SMP_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   ref_tick,
	input  wire logic                   dld_locked,
	input  wire logic                   chip_enable_pin,
	input  wire logic                   output_buffer_pin,
	input  wire logic [1:0]             core_pick_value,
	input  wire logic                   core_cal_done,
	input  wire logic [1:0]             core_cal_core,
	input  wire logic                   core_invalid,
	input  wire logic [4:0]             steady_pump_gain,
	output logic [31:0]                 mode_power_output_control,
	output logic [31:0]                 phase_detector_fast_settle_control,
	output logic                        rf_out_a_en,
	output logic                        rf_out_b_en,
	output logic [1:0]                  out_a_source,
	output logic [1:0]                  out_b_source,
	output logic                        fb_from_divider,
	output logic                        pll_pwr_en,
	output logic                        vco_pwr_en,
	output logic                        ext_in_pwr_en,
	output logic                        regulators_en,
	output logic [2:0]                  power_state,
	output logic [2:0]                  ref_range_code,
	output logic [1:0]                  core_start,
	output logic                        core_force,
	output logic [11:0]                 pd_min_pulse_ps,
	output logic                        fast_settle_active,
	output logic [4:0]                  pump_gain,
	output logic                        soft_reset_pulse
);
	// ****************************************
	// helpers
	// ****************************************
	function automatic smp_pkg::smp_pwr_t pwr_decode(input logic [2:0] sel, input logic ce);
		unique case (sel)
			3'h0:    pwr_decode = smp_pkg::SMP_PWR_UP;
			3'h3:    pwr_decode = smp_pkg::SMP_PWR_PARTIAL;
			3'h4:    pwr_decode = ce ? smp_pkg::SMP_PWR_UP : smp_pkg::SMP_PWR_FULL;
			3'h6:    pwr_decode = ce ? smp_pkg::SMP_PWR_UP : smp_pkg::SMP_PWR_PARTIAL;
			3'h7:    pwr_decode = ce ? smp_pkg::SMP_PWR_PARTIAL : smp_pkg::SMP_PWR_FULL;
			// reserved codes fall to full down, the safe side
			default: pwr_decode = smp_pkg::SMP_PWR_FULL;
		endcase
	endfunction

	function automatic logic [11:0] pd_ps(input logic [2:0] code);
		unique case (code)
			3'h0: pd_ps = `SMP_PD_PS_0;
			3'h1: pd_ps = `SMP_PD_PS_1;
			3'h2: pd_ps = `SMP_PD_PS_2;
			3'h3: pd_ps = `SMP_PD_PS_3;
			3'h4: pd_ps = `SMP_PD_PS_4;
			3'h5: pd_ps = `SMP_PD_PS_5;
			3'h6: pd_ps = `SMP_PD_PS_6;
			3'h7: pd_ps = `SMP_PD_PS_7;
		endcase
	endfunction

	// ****************************************
	// configuration words
	// ****************************************
	logic [31:0] r5_reg;
	logic [31:0] r4_reg;
	wire         wr5        = reg_wr && (reg_addr == `SMP_ADDR_MODE_POWER);
	wire         wr4        = reg_wr && (reg_addr == `SMP_ADDR_PD_FS);
	wire         wr_freq    = reg_wr && (reg_addr == `SMP_ADDR_FREQ_PROG);
	wire         soft_reset = wr5 && reg_wdata[`SMP_R5_RESET_BIT];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r5_reg <= `SMP_R5_RESET_VAL;
			r4_reg <= `SMP_R4_RESET_VAL;
		end else if (soft_reset) begin
			r5_reg <= `SMP_R5_RESET_VAL;
			r4_reg <= `SMP_R4_RESET_VAL;
		end else begin
			if (wr5)
				r5_reg <= reg_wdata;
			if (wr4)
				r4_reg <= reg_wdata;
		end
	end

	// field views
	wire       mute_on_unlock        = r5_reg[`SMP_R5_MUTE_BIT];
	wire       buffer_pin_ignore     = r5_reg[`SMP_R5_BUFIGN_BIT];
	wire [1:0] core_method           = r5_reg[`SMP_R5_METHOD_MSB:`SMP_R5_METHOD_LSB];
	wire [1:0] out_b_source_f        = r5_reg[`SMP_R5_OUTB_MSB:`SMP_R5_OUTB_LSB];
	wire [1:0] out_a_source_f        = r5_reg[`SMP_R5_OUTA_MSB:`SMP_R5_OUTA_LSB];
	wire       zero_delay_feedback   = r5_reg[`SMP_R5_ZDLY_BIT];
	wire [1:0] op_mode               = r5_reg[`SMP_R5_OPMODE_MSB:`SMP_R5_OPMODE_LSB];
	wire [2:0] power_state_select    = r5_reg[`SMP_R5_PWR_MSB:`SMP_R5_PWR_LSB];
	wire [2:0] pd_min_pulse_select   = r4_reg[`SMP_R4_PDDLY_MSB:`SMP_R4_PDDLY_LSB];
	wire       fast_settle_force     = r4_reg[`SMP_R4_FORCE_BIT];
	wire [11:0] fast_settle_timeout  = r4_reg[`SMP_R4_TOC_MSB:`SMP_R4_TOC_LSB];
	wire [4:0] fast_settle_pump_gain = r4_reg[`SMP_R4_FSGAIN_MSB:`SMP_R4_FSGAIN_LSB];

	// ****************************************
	// fast-settle
	// ****************************************
	logic [11:0] fs_count;

	smp_fs_counter u_fs_counter (
		.clk      (clk),
		.rstn     (rstn),
		.clr      (soft_reset),
		.load     (wr_freq),
		.timeout  (fast_settle_timeout),
		.ref_tick (ref_tick),
		.count    (fs_count)
	);

	// zero timeout disables even when forced; forced with zero is invalid
	assign fast_settle_active = (fast_settle_timeout != 12'h000)
		&& (fast_settle_force || (fs_count != 12'h000));

	// ****************************************
	// core selection
	// ****************************************
	logic       core_used_reg;
	logic [1:0] last_core_reg;
	logic [1:0] skip_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_used_reg <= 1'b0;
			last_core_reg <= 2'h0;
			skip_reg      <= 2'h0;
		end else if (soft_reset) begin
			core_used_reg <= 1'b0;
			last_core_reg <= 2'h0;
			skip_reg      <= 2'h0;
		end else begin
			if (core_cal_done) begin
				core_used_reg <= 1'b1;
				last_core_reg <= core_cal_core;
			end
			if (wr_freq)
				skip_reg <= 2'h0;
			else if (core_invalid && core_method == smp_pkg::SMP_CORE_START)
				skip_reg <= skip_reg + 2'h1;
		end
	end

	wire [1:0] core_from_last = core_used_reg ? last_core_reg : 2'h0;
	wire [1:0] core_from_pick = core_pick_value + skip_reg;
	// reserved method behaves as method 0
	wire [1:0] core_start_next = (core_method == smp_pkg::SMP_CORE_START) ? core_from_pick :
		(core_method == smp_pkg::SMP_CORE_FORCE) ? core_pick_value : core_from_last;
	wire       core_force_next = (core_method == smp_pkg::SMP_CORE_FORCE);

	// ****************************************
	// power and output decode
	// ****************************************
	smp_pkg::smp_pwr_t pwr_next;
	assign pwr_next = pwr_decode(power_state_select, chip_enable_pin);

	wire powered     = (pwr_next == smp_pkg::SMP_PWR_UP);
	wire muted       = mute_on_unlock && !dld_locked;
	wire buf_gate    = buffer_pin_ignore || output_buffer_pin;
	wire out_common  = powered && !muted && buf_gate;
	wire out_a_next  = out_common && (out_a_source_f != smp_pkg::SMP_SRC_RSVD);
	wire out_b_next  = out_common && (out_b_source_f != smp_pkg::SMP_SRC_RSVD);
	// reserved operating modes behave as mode 0
	wire vco_mode    = (op_mode != 2'h1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rf_out_a_en      <= 1'b0;
			rf_out_b_en      <= 1'b0;
			pll_pwr_en       <= 1'b0;
			vco_pwr_en       <= 1'b0;
			ext_in_pwr_en    <= 1'b0;
			regulators_en    <= 1'b0;
			power_state      <= smp_pkg::SMP_PWR_FULL;
			core_start       <= 2'h0;
			core_force       <= 1'b0;
			pd_min_pulse_ps  <= `SMP_PD_PS_0;
			pump_gain        <= 5'h00;
			soft_reset_pulse <= 1'b0;
		end else begin
			rf_out_a_en      <= out_a_next;
			rf_out_b_en      <= out_b_next;
			pll_pwr_en       <= powered;
			vco_pwr_en       <= powered && vco_mode;
			ext_in_pwr_en    <= 1'b0;
			regulators_en    <= (pwr_next != smp_pkg::SMP_PWR_FULL);
			power_state      <= pwr_next;
			core_start       <= core_start_next;
			core_force       <= core_force_next;
			pd_min_pulse_ps  <= pd_ps(pd_min_pulse_select);
			pump_gain        <= fast_settle_active ? fast_settle_pump_gain : steady_pump_gain;
			soft_reset_pulse <= soft_reset;
		end
	end

	assign out_a_source                        = out_a_source_f;
	assign out_b_source                        = out_b_source_f;
	assign fb_from_divider                     = zero_delay_feedback;
	assign ref_range_code                      = r5_reg[`SMP_R5_RANGE_MSB:`SMP_R5_RANGE_LSB];
	assign mode_power_output_control           = r5_reg;
	assign phase_detector_fast_settle_control  = r4_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence reset_write_s;
		wr5 && reg_wdata[`SMP_R5_RESET_BIT];
	endsequence
	sequence reset_release_s;
		soft_reset_pulse && r5_reg == `SMP_R5_RESET_VAL ##1 !soft_reset_pulse;
	endsequence

	unlock_mute_a: assert property (mute_on_unlock && !dld_locked |=> !rf_out_a_en && !rf_out_b_en)
		else $error("outputs live while unlocked and muting");
	buffer_pin_a: assert property (!buffer_pin_ignore && !output_buffer_pin |=> !rf_out_a_en && !rf_out_b_en)
		else $error("buffer pin low did not gate outputs");
	core_last_a: assert property (core_method == 2'h0 |=> core_start == $past(core_from_last))
		else $error("method 0 core wrong");
	core_pick_a: assert property (core_method == 2'h1 && skip_reg == 2'h0 |=> core_start == $past(core_pick_value))
		else $error("method 1 did not start at pick");
	core_force_a: assert property (core_method == 2'h2 |=> core_force && core_start == $past(core_pick_value))
		else $error("method 2 did not force pick");
	source_rsvd_a: assert property (out_a_source_f == 2'h3 |=> !rf_out_a_en)
		else $error("reserved source enabled output");
	pll_only_a: assert property (op_mode == 2'h1 |=> !vco_pwr_en && !ext_in_pwr_en)
		else $error("pll-only mode powered vco");
	ce_power_a: assert property (power_state_select == 3'h7 && !chip_enable_pin |=> power_state == 3'b010)
		else $error("code 7 with ce low not full down");
	soft_reset_a: assert property (reset_write_s |=> reset_release_s)
		else $error("register reset did not restore and release");
	plain_write_a: assert property (wr5 && !reg_wdata[`SMP_R5_RESET_BIT] && !wr4 |=> $stable(r4_reg))
		else $error("plain write disturbed other word");
	pulse_width_a: assert property (pd_min_pulse_select == 3'h7 |=> pd_min_pulse_ps == `SMP_PD_PS_7)
		else $error("pulse width table wrong");
	fs_zero_a: assert property (fast_settle_timeout == 12'h000 |-> !fast_settle_active)
		else $error("fast-settle with zero timeout");
	fs_gain_a: assert property (fast_settle_active |=> pump_gain == $past(fast_settle_pump_gain))
		else $error("fast-settle gain not applied");
endmodule

// >>> shared/smp_regs.svh
// register offsets, field positions, reset values and code tables
// assumes inclusion by bare name from design files
`ifndef SMP_REGS_SVH
`define SMP_REGS_SVH

// ****************************************
// word addresses on the serial write port
// ****************************************
`define SMP_ADDR_W            4
`define SMP_ADDR_MODE_POWER   4'h5
`define SMP_ADDR_PD_FS        4'h4
`define SMP_ADDR_FREQ_PROG    4'h0

// ****************************************
// mode/power/output word fields
// ****************************************
`define SMP_R5_MUTE_BIT       0
`define SMP_R5_RANGE_LSB      1
`define SMP_R5_RANGE_MSB      3
`define SMP_R5_BUFIGN_BIT     4
`define SMP_R5_METHOD_LSB     5
`define SMP_R5_METHOD_MSB     6
`define SMP_R5_OUTB_LSB       7
`define SMP_R5_OUTB_MSB       8
`define SMP_R5_OUTA_LSB       9
`define SMP_R5_OUTA_MSB       10
`define SMP_R5_ZDLY_BIT       11
`define SMP_R5_OPMODE_LSB     12
`define SMP_R5_OPMODE_MSB     13
`define SMP_R5_PWR_LSB        14
`define SMP_R5_PWR_MSB        16
`define SMP_R5_RESET_BIT      17
`define SMP_R5_RESET_VAL      32'h0000_0000

// ****************************************
// phase detector / fast-settle word fields
// ****************************************
`define SMP_R4_PDDLY_LSB      0
`define SMP_R4_PDDLY_MSB      2
`define SMP_R4_FORCE_BIT      3
`define SMP_R4_TOC_LSB        4
`define SMP_R4_TOC_MSB        15
`define SMP_R4_FSGAIN_LSB     16
`define SMP_R4_FSGAIN_MSB     20
`define SMP_R4_RESET_VAL      32'h0000_0000

// ****************************************
// minimum pump on-time per code, in ps
// ****************************************
`define SMP_PD_PS_0           12'h172
`define SMP_PD_PS_1           12'h2F8
`define SMP_PD_PS_2           12'h46A
`define SMP_PD_PS_3           12'h5B4
`define SMP_PD_PS_4           12'h6EA
`define SMP_PD_PS_5           12'h816
`define SMP_PD_PS_6           12'h92E
`define SMP_PD_PS_7           12'hA28

`endif

// >>> shared/smp_pkg.sv
// types shared by the mode/power/fast-settle control block
// assumes nothing beyond a SystemVerilog compiler
package smp_pkg;
	typedef enum logic [2:0] {
		SMP_PWR_UP      = 3'b001,
		SMP_PWR_FULL    = 3'b010,
		SMP_PWR_PARTIAL = 3'b100
	} smp_pwr_t;

	typedef enum logic [1:0] {
		SMP_CORE_LAST   = 2'h0,
		SMP_CORE_START  = 2'h1,
		SMP_CORE_FORCE  = 2'h2,
		SMP_CORE_RSVD   = 2'h3
	} smp_core_method_t;

	typedef enum logic [1:0] {
		SMP_SRC_VCO     = 2'h0,
		SMP_SRC_DIV     = 2'h1,
		SMP_SRC_EXT     = 2'h2,
		SMP_SRC_RSVD    = 2'h3
	} smp_src_t;
endpackage

// >>> hw/smp_fs_counter.sv
// fast-settle timeout counter, one step per two reference cycles
// assumes ref_tick is a one-cycle pulse per reference cycle
`timescale 1ns/1ps
module smp_fs_counter (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clr,
	input  wire logic        load,
	input  wire logic [11:0] timeout,
	input  wire logic        ref_tick,
	output logic      [11:0] count
);
	logic [11:0] count_reg;
	logic        half_reg;
	wire         step = ref_tick && (count_reg != 12'h000);

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 12'h000;
			half_reg  <= 1'b0;
		end else if (clr) begin
			count_reg <= 12'h000;
			half_reg  <= 1'b0;
		end else if (load) begin
			count_reg <= timeout;
			half_reg  <= 1'b0;
		end else if (step) begin
			half_reg  <= ~half_reg;
			// second reference cycle of each pair: 2*N cycles in total
			if (half_reg)
				count_reg <= count_reg - 12'h001;
		end
	end

	assign count = count_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	counter_load_a: assert property (load && !clr |=> count_reg == $past(timeout))
		else $error("timeout counter did not load");
	counter_pair_a: assert property (step && !load && !clr && half_reg |=> count_reg == $past(count_reg) - 12'h001)
		else $error("counter did not step after two reference cycles");
endmodule

// >>> sim/tb.sv
// self-checking bench for smp_ctrl: word writes, field decode, fast-settle counter
// assumes smp_pkg and smp_regs.svh are on the compile and include paths
`timescale 1ns/1ps
`include "smp_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("Error %0t: got %0h want %0h", $time, g, e); end end
module tb;
	logic                   clk, rstn, reg_wr, ref_tick, dld_locked, chip_enable_pin, output_buffer_pin;
	logic                   core_cal_done, core_invalid, rf_out_a_en, rf_out_b_en, fb_from_divider;
	logic                   pll_pwr_en, vco_pwr_en, ext_in_pwr_en, regulators_en, core_force;
	logic                   fast_settle_active, soft_reset_pulse;
	logic [`SMP_ADDR_W-1:0] reg_addr;
	logic [31:0]            reg_wdata, mode_power_output_control, phase_detector_fast_settle_control;
	logic [1:0]             core_pick_value, core_cal_core, out_a_source, out_b_source, core_start;
	logic [4:0]             steady_pump_gain, pump_gain;
	logic [2:0]             power_state, ref_range_code;
	logic [11:0]            pd_min_pulse_ps;
	int                     num_errors, n_compared, cnt;
	logic [11:0]            pd_tab [8] = '{`SMP_PD_PS_0, `SMP_PD_PS_1, `SMP_PD_PS_2, `SMP_PD_PS_3,
	                                       `SMP_PD_PS_4, `SMP_PD_PS_5, `SMP_PD_PS_6, `SMP_PD_PS_7};
	localparam logic [3:0]  a_mode = `SMP_ADDR_MODE_POWER;
	localparam logic [3:0]  a_pd   = `SMP_ADDR_PD_FS;
	localparam logic [3:0]  a_freq = `SMP_ADDR_FREQ_PROG;

	smp_ctrl i_dut (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .ref_tick, .dld_locked, .chip_enable_pin,
		.output_buffer_pin, .core_pick_value, .core_cal_done, .core_cal_core, .core_invalid,
		.steady_pump_gain, .mode_power_output_control, .phase_detector_fast_settle_control,
		.rf_out_a_en, .rf_out_b_en, .out_a_source, .out_b_source, .fb_from_divider, .pll_pwr_en,
		.vco_pwr_en, .ext_in_pwr_en, .regulators_en, .power_state, .ref_range_code, .core_start,
		.core_force, .pd_min_pulse_ps, .fast_settle_active, .pump_gain, .soft_reset_pulse);

	// ****
	// helpers
	// ****
	function automatic logic [31:0] f5(input logic mu, input logic [2:0] rg, input logic ig,
		input logic [1:0] me, input logic [1:0] ob, input logic [1:0] oa, input logic zd,
		input logic [1:0] md, input logic [2:0] pw);
		return {15'h0, pw, md, zd, oa, ob, me, ig, rg, mu};
	endfunction

	function automatic logic [31:0] f4(input logic [2:0] pd, input logic fo, input logic [11:0] n,
		input logic [4:0] g);
		return {11'h0, g, n, fo, pd};
	endfunction

	function automatic smp_pkg::smp_pwr_t pwr_exp(input logic [2:0] p, input logic ce);
		case (p)
			3'h0: return smp_pkg::SMP_PWR_UP;
			3'h3: return smp_pkg::SMP_PWR_PARTIAL;
			3'h4: return ce ? smp_pkg::SMP_PWR_UP : smp_pkg::SMP_PWR_FULL;
			3'h6: return ce ? smp_pkg::SMP_PWR_UP : smp_pkg::SMP_PWR_PARTIAL;
			3'h7: return ce ? smp_pkg::SMP_PWR_PARTIAL : smp_pkg::SMP_PWR_FULL;
			default: return smp_pkg::SMP_PWR_FULL;
		endcase
	endfunction

	// one-cycle strobe, as the serial shifter delivers a whole word
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// decoded outputs sit two flops behind the write
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic tick;
		@(posedge clk);
		ref_tick <= 1'b1;
		@(posedge clk);
		ref_tick <= 1'b0;
	endtask

	task automatic print_verdict;
		$display("Errors: %0d, comparisons: %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****
	// clock, watchdog
	// ****
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// longest test is the full-scale timeout, about 16.4k cycles
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		print_verdict();
	end

	// ****
	// tests
	// ****
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		ref_tick = 1'b0;
		dld_locked = 1'b1;
		chip_enable_pin = 1'b1;
		output_buffer_pin = 1'b1;
		core_pick_value = 2'h1;
		core_cal_done = 1'b0;
		core_cal_core = 2'h0;
		core_invalid = 1'b0;
		steady_pump_gain = 5'h03;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		settle();
		`CHK(mode_power_output_control, 32'h0)
		`CHK(power_state, smp_pkg::SMP_PWR_UP)
		`CHK(pd_min_pulse_ps, 12'h172)
		`CHK(core_start, 2'h0)
		@(posedge clk);
		core_cal_done <= 1'b1;
		core_cal_core <= 2'h2;
		@(posedge clk);
		core_cal_done <= 1'b0;
		settle();
		`CHK(core_start, 2'h2)
		wr(a_mode, f5(0, 0, 0, 2'h1, 0, 0, 0, 0, 0));
		settle();
		`CHK(core_start, 2'h1)
		`CHK(core_force, 1'b0)
		@(posedge clk);
		core_invalid <= 1'b1;
		@(posedge clk);
		core_invalid <= 1'b0;
		settle();
		`CHK(core_start, 2'h2)
		@(posedge clk);
		core_pick_value <= 2'h3;
		wr(a_mode, f5(0, 0, 0, 2'h2, 0, 0, 0, 0, 0));
		settle();
		`CHK(core_start, 2'h3)
		`CHK(core_force, 1'b1)
		wr(a_mode, f5(0, 3'h4, 0, 0, 2'h1, 2'h2, 1, 0, 0));
		settle();
		`CHK(mode_power_output_control, 32'h0000_0C88)
		`CHK(ref_range_code, 3'h4)
		`CHK(fb_from_divider, 1'b1)
		for (int s = 0; s < 4; s++) begin
			wr(a_mode, f5(0, 0, 0, 0, s[1:0], s[1:0], 0, 0, 0));
			settle();
			`CHK(out_a_source, s[1:0])
			`CHK(out_b_source, s[1:0])
			`CHK(rf_out_a_en, s != 3)
			`CHK(rf_out_b_en, s != 3)
		end
		`CHK(fb_from_divider, 1'b0)
		for (int m = 0; m < 2; m++) begin
			wr(a_mode, f5(1, 0, 0, 0, 0, 0, 0, m[1:0], 0));
			settle();
			`CHK(pll_pwr_en, 1'b1)
			`CHK(vco_pwr_en, m == 0)
			`CHK(ext_in_pwr_en, 1'b0)
		end
		@(posedge clk);
		dld_locked <= 1'b0;
		settle();
		`CHK(rf_out_a_en, 1'b0)
		`CHK(rf_out_b_en, 1'b0)
		wr(a_mode, f5(0, 0, 0, 0, 0, 0, 0, 0, 0));
		settle();
		`CHK(rf_out_a_en, 1'b1)
		@(posedge clk);
		output_buffer_pin <= 1'b0;
		settle();
		`CHK(rf_out_b_en, 1'b0)
		wr(a_mode, f5(0, 0, 1, 0, 0, 0, 0, 0, 0));
		settle();
		`CHK(rf_out_b_en, 1'b1)
		for (int p = 0; p < 16; p++) begin
			@(posedge clk);
			chip_enable_pin <= p[0];
			wr(a_mode, f5(0, 0, 0, 0, 0, 0, 0, 0, p[3:1]));
			settle();
			`CHK(power_state, pwr_exp(p[3:1], p[0]))
			`CHK(regulators_en, pwr_exp(p[3:1], p[0]) != smp_pkg::SMP_PWR_FULL)
		end
		for (int d = 0; d < 8; d++) begin
			wr(a_pd, f4(d[2:0], 0, 0, 0));
			settle();
			`CHK(pd_min_pulse_ps, pd_tab[d])
		end
		// full-scale timeout: 2 x 4095 reference ticks
		wr(a_pd, f4(0, 0, 12'hFFF, 5'h15));
		settle();
		`CHK(phase_detector_fast_settle_control, 32'h0015_FFF0)
		`CHK(fast_settle_active, 1'b0)
		`CHK(pump_gain, 5'h03)
		wr(a_freq, 32'h0);
		#1;
		`CHK(fast_settle_active, 1'b1)
		repeat (8189) tick();
		settle();
		`CHK(fast_settle_active, 1'b1)
		`CHK(pump_gain, 5'h15)
		tick();
		settle();
		`CHK(fast_settle_active, 1'b0)
		`CHK(pump_gain, 5'h03)
		wr(a_pd, f4(0, 1, 12'h001, 5'h15));
		wr(a_freq, 32'h0);
		repeat (4) tick();
		settle();
		`CHK(fast_settle_active, 1'b1)
		wr(a_pd, f4(0, 1, 12'h000, 5'h15));
		wr(a_freq, 32'h0);
		settle();
		`CHK(fast_settle_active, 1'b0)
		// plain mode write must leave the other word and core memory alone
		wr(a_mode, f5(0, 0, 0, 0, 0, 0, 0, 0, 0));
		settle();
		`CHK(phase_detector_fast_settle_control, 32'h0015_0008)
		`CHK(core_start, 2'h2)
		// pulse may land on either edge after the strobe, so count it
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a_mode;
		reg_wdata <= f5(1, 3'h2, 1, 2'h1, 2'h1, 2'h1, 1, 2'h1, 3'h1) | 32'h0002_0000;
		cnt = 0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			reg_wr <= 1'b0;
			#1 cnt += int'(soft_reset_pulse === 1'b1);
		end
		`CHK(cnt, 1)
		`CHK(mode_power_output_control, 32'h0)
		`CHK(phase_detector_fast_settle_control, 32'h0)
		`CHK(power_state, smp_pkg::SMP_PWR_UP)
		`CHK(core_start, 2'h0)
		print_verdict();
	end
endmodule
